// >>> include/wwr_pkg.sv
// Overview of operation
// (RQ1) Watchdog cycle tick is one hundred oscillator periods; all timing counts ticks (the supply glitch filter counts 2000 oscillator periods instead).
// (RQ2) After power-on, reset output stays low 64 ticks, then goes high.
// (RQ3) Reset output rising edge starts a 32-tick closed window.
// (RQ4) Valid trigger inside closed window is a pretrigger failure; controller must avoid it.
// (RQ5) Open window follows closed window; ends on trigger, else after 32 ticks.
// (RQ6) Trigger input sampled once per tick; high, high, low, low is a trigger.
// (RQ7) Trigger in open window, or supply up/down, restarts with a fresh closed window.
// (RQ8) Missed open window or pretrigger drives reset output low.
// (RQ9) Watchdog reset starts 64 ticks after closed-window start, lasts 64 ticks.
// (RQ10) Trigger completing with fourth sample in open window is correct, not pretrigger.
// (RQ11) With reset output high, system enable rises on first valid trigger.
// (RQ12) System enable drops at once on pretrigger, missed trigger or power-down.
// (RQ13) Filtered supply-low forces reset low; recovery reruns the full reset delay.
// (RQ14) After watchdog reset, release reset output, restart closed window, enable stays low.
package wwr_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int unsigned CLK_PERIOD_NS        = 50;
    localparam int unsigned TICK_DIV             = 100;
    localparam int unsigned RESET_DELAY_TICKS    = 64;
    localparam int unsigned CLOSED_WINDOW_TICKS  = 32;
    localparam int unsigned OPEN_WINDOW_TICKS    = 32;
    localparam int unsigned WD_START_TICKS       = 64;
    localparam int unsigned WD_RESET_TICKS       = 64;
    localparam int unsigned GLITCH_FILTER_TIME_NS = 100000;
    localparam int unsigned GLITCH_FILTER_CYC    =
        (GLITCH_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int unsigned TICK_W  = 7;
    localparam int unsigned CNT_W   = 6;
    localparam int unsigned FILT_W  = 11;

    localparam logic [TICK_W-1:0] TICK_LAST         = TICK_W'(TICK_DIV - 1);
    localparam logic [CNT_W-1:0]  RESET_DELAY_LAST  = CNT_W'(RESET_DELAY_TICKS - 1);
    localparam logic [CNT_W-1:0]  CLOSED_LAST       = CNT_W'(CLOSED_WINDOW_TICKS - 1);
    localparam logic [CNT_W-1:0]  OPEN_LAST         =
        CNT_W'(CLOSED_WINDOW_TICKS + OPEN_WINDOW_TICKS - 1);
    localparam logic [CNT_W-1:0]  WD_START_LAST     = CNT_W'(WD_START_TICKS - 1);
    localparam logic [CNT_W-1:0]  WD_RESET_LAST     = CNT_W'(WD_RESET_TICKS - 1);
    localparam logic [FILT_W-1:0] FILTER_LAST       = FILT_W'(GLITCH_FILTER_CYC - 1);

    // ****************************************
    // trigger sampling
    // ****************************************
    localparam int unsigned    SAMPLE_W        = 4;
    localparam logic [3:0]     TRIGGER_PATTERN = 4'hC;

    // ****************************************
    // sequencer states
    // ****************************************
    typedef enum logic [4:0] {
        ST_PWR_DELAY = 5'h01,
        ST_CLOSED    = 5'h02,
        ST_OPEN      = 5'h04,
        ST_WD_WAIT   = 5'h08,
        ST_WD_RESET  = 5'h10
    } wwr_state_t;

endpackage : wwr_pkg

// >>> design/wwr_tick_gen.sv
`timescale 1ns/10ps
module wwr_tick_gen (
    input  wire logic clk_sys_i,
    input  wire logic reset_i,
    output logic      tick_o
);

    logic [wwr_pkg::TICK_W-1:0] div_cnt;

    // one pulse per hundred oscillator periods
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            div_cnt <= '0;
            tick_o  <= 1'b0;
        end else if (div_cnt == wwr_pkg::TICK_LAST) begin // [RQ1]
            div_cnt <= '0;
            tick_o  <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 1'b1;
            tick_o  <= 1'b0;
        end
    end

endmodule : wwr_tick_gen

// >>> design/wwr_top.sv
`timescale 1ns/10ps
module wwr_top (
    input  wire logic clk_sys_i,
    input  wire logic reset_i,
    input  wire logic supply_low_i,
    input  wire logic trigger_input_i,
    output logic      mcu_reset_output_o,
    output logic      mcu_reset_output_oe_o,
    output logic      system_enable_output_o,
    output logic      system_enable_output_oe_o,
    output logic      trigger_accepted_o,
    output logic      pretrigger_fault_o,
    output logic      missed_trigger_o,
    output logic      supply_fail_o
);

    // ****************************************
    // declarations
    // ****************************************
    logic                              tick;
    logic [wwr_pkg::FILT_W-1:0]        filt_cnt;
    logic                              supply_fail;
    logic                              supply_fail_q;
    logic [wwr_pkg::SAMPLE_W-1:0]      samples;
    logic [wwr_pkg::SAMPLE_W-1:0]      next_samples;
    logic                              trig_valid;
    wwr_pkg::wwr_state_t               state;
    logic [wwr_pkg::CNT_W-1:0]         win_cnt;
    logic                              reset_level;
    logic                              enable_level;

    // ****************************************
    // watchdog cycle timebase
    // ****************************************
    // divider restarts on power-down so recovery waits whole ticks, not a partial one
    wwr_tick_gen wwr_tick_gen_i (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i || supply_fail), // [RQ13]
        .tick_o    (tick)
    );

    // ****************************************
    // supply glitch filter
    // ****************************************
    // short dips on the comparator are ignored; only a low that outlasts
    // the filter time counts as a power-down
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            filt_cnt    <= '0;
            supply_fail <= 1'b0;
        end else if (!supply_low_i) begin
            filt_cnt    <= '0;
            supply_fail <= 1'b0;
        end else if (filt_cnt == wwr_pkg::FILTER_LAST) begin // [RQ13]
            supply_fail <= 1'b1;
        end else begin
            filt_cnt <= filt_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            supply_fail_q <= 1'b0;
        end else begin
            supply_fail_q <= supply_fail;
        end
    end

    // ****************************************
    // trigger sampler
    // ****************************************
    // newest sample in bit 0; pattern high, high, low, low
    always_comb begin
        next_samples = {samples[wwr_pkg::SAMPLE_W-2:0], trigger_input_i};
    end

    always_comb begin
        trig_valid = tick && (next_samples == wwr_pkg::TRIGGER_PATTERN); // [RQ6]
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            samples <= '0;
        end else if (tick) begin // [RQ6]
            samples <= next_samples;
        end
    end

    // ****************************************
    // window sequencer
    // ****************************************
    // win_cnt counts ticks since the latest closed-window start, so the
    // watchdog reset lands at the same point whether the fault was a
    // pretrigger or a missed open window
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            state   <= wwr_pkg::ST_PWR_DELAY;
            win_cnt <= '0;
        end else if (supply_fail) begin // [RQ13]
            state   <= wwr_pkg::ST_PWR_DELAY;
            win_cnt <= '0;
        end else if (tick) begin
            case (state)
                wwr_pkg::ST_PWR_DELAY: begin
                    if (win_cnt == wwr_pkg::RESET_DELAY_LAST) begin // [RQ2] [RQ13]
                        state   <= wwr_pkg::ST_CLOSED; // [RQ3] [RQ7]
                        win_cnt <= '0;
                    end else begin
                        win_cnt <= win_cnt + 1'b1;
                    end
                end
                wwr_pkg::ST_CLOSED: begin
                    win_cnt <= win_cnt + 1'b1;
                    if (trig_valid) begin
                        state <= wwr_pkg::ST_WD_WAIT; // [RQ4]
                    end else if (win_cnt == wwr_pkg::CLOSED_LAST) begin // [RQ3]
                        state <= wwr_pkg::ST_OPEN; // [RQ5]
                    end
                end
                wwr_pkg::ST_OPEN: begin
                    // a trigger finishing here counts even if its first
                    // three samples fell in the closed window
                    if (trig_valid) begin // [RQ10]
                        state   <= wwr_pkg::ST_CLOSED; // [RQ7]
                        win_cnt <= '0;
                    end else if (win_cnt == wwr_pkg::OPEN_LAST) begin // [RQ5] [RQ8]
                        state   <= wwr_pkg::ST_WD_RESET; // [RQ9]
                        win_cnt <= '0;
                    end else begin
                        win_cnt <= win_cnt + 1'b1;
                    end
                end
                wwr_pkg::ST_WD_WAIT: begin
                    if (win_cnt == wwr_pkg::WD_START_LAST) begin // [RQ9]
                        state   <= wwr_pkg::ST_WD_RESET; // [RQ8]
                        win_cnt <= '0;
                    end else begin
                        win_cnt <= win_cnt + 1'b1;
                    end
                end
                wwr_pkg::ST_WD_RESET: begin
                    if (win_cnt == wwr_pkg::WD_RESET_LAST) begin // [RQ9]
                        state   <= wwr_pkg::ST_CLOSED; // [RQ14]
                        win_cnt <= '0;
                    end else begin
                        win_cnt <= win_cnt + 1'b1;
                    end
                end
                default: begin
                    state   <= wwr_pkg::ST_PWR_DELAY;
                    win_cnt <= '0;
                end
            endcase
        end
    end

    // ****************************************
    // reset output level
    // ****************************************
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            reset_level <= 1'b0; // [RQ2]
        end else if (supply_fail) begin
            reset_level <= 1'b0; // [RQ13]
        end else if (tick) begin
            case (state)
                wwr_pkg::ST_PWR_DELAY: begin
                    if (win_cnt == wwr_pkg::RESET_DELAY_LAST) begin
                        reset_level <= 1'b1; // [RQ2]
                    end
                end
                wwr_pkg::ST_OPEN: begin
                    if (!trig_valid && win_cnt == wwr_pkg::OPEN_LAST) begin
                        reset_level <= 1'b0; // [RQ8]
                    end
                end
                wwr_pkg::ST_WD_WAIT: begin
                    if (win_cnt == wwr_pkg::WD_START_LAST) begin
                        reset_level <= 1'b0; // [RQ8] [RQ9]
                    end
                end
                wwr_pkg::ST_WD_RESET: begin
                    if (win_cnt == wwr_pkg::WD_RESET_LAST) begin
                        reset_level <= 1'b1; // [RQ14]
                    end
                end
                default: begin
                    reset_level <= reset_level;
                end
            endcase
        end
    end

    // ****************************************
    // system enable level
    // ****************************************
    // enable drops at the fault itself: well ahead of the reset on a pretrigger, together with it on a miss or power-down
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            enable_level <= 1'b0;
        end else if (supply_fail) begin
            enable_level <= 1'b0; // [RQ12]
        end else if (tick) begin
            if (state == wwr_pkg::ST_CLOSED && trig_valid) begin
                enable_level <= 1'b0; // [RQ12]
            end else if (state == wwr_pkg::ST_OPEN && trig_valid && reset_level) begin
                enable_level <= 1'b1; // [RQ11]
            end else if (state == wwr_pkg::ST_OPEN && win_cnt == wwr_pkg::OPEN_LAST) begin
                enable_level <= 1'b0; // [RQ12]
            end
        end
    end

    // ****************************************
    // event pulses
    // ****************************************
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            trigger_accepted_o <= 1'b0;
            pretrigger_fault_o <= 1'b0;
            missed_trigger_o   <= 1'b0;
        end else begin
            trigger_accepted_o <= !supply_fail && trig_valid
                                  && state == wwr_pkg::ST_OPEN;
            pretrigger_fault_o <= !supply_fail && trig_valid
                                  && state == wwr_pkg::ST_CLOSED; // [RQ4]
            missed_trigger_o   <= !supply_fail && tick && !trig_valid
                                  && state == wwr_pkg::ST_OPEN
                                  && win_cnt == wwr_pkg::OPEN_LAST; // [RQ8]
        end
    end

    // ****************************************
    // open-drain pins
    // ****************************************
    // pins are one cycle behind the internal levels so every output is a flop
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            mcu_reset_output_o        <= 1'b0;
            mcu_reset_output_oe_o     <= 1'b1;
            system_enable_output_o    <= 1'b0;
            system_enable_output_oe_o <= 1'b1;
            supply_fail_o             <= 1'b0;
        end else begin
            mcu_reset_output_o        <= reset_level;
            mcu_reset_output_oe_o     <= !reset_level;
            system_enable_output_o    <= enable_level;
            system_enable_output_oe_o <= !enable_level;
            supply_fail_o             <= supply_fail_q;
        end
    end

endmodule : wwr_top

// >>> tb/wwr_mcu_model.sv
`timescale 1ns/10ps
module wwr_mcu_model (
    input  wire logic clk_sys_i,
    input  wire logic fire_i,
    output logic      trigger_o
);
    // 200 clk high spans exactly two tick samples, then the line rests low
    localparam int HIGH_CYC = 200;
    int cnt = 0;
    always_ff @(posedge clk_sys_i) begin
        if (fire_i) begin // only when commanded
            cnt <= HIGH_CYC; // high, high, then low, low
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
    end
    assign trigger_o = (cnt != 0);
endmodule : wwr_mcu_model

// >>> tb/wwr_top_sva.sv
`timescale 1ns/10ps
module wwr_top_sva (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic supply_low_i,
    input wire logic trigger_input_i,
    input wire logic mcu_reset_output_o,
    input wire logic mcu_reset_output_oe_o,
    input wire logic system_enable_output_o,
    input wire logic system_enable_output_oe_o,
    input wire logic trigger_accepted_o,
    input wire logic pretrigger_fault_o,
    input wire logic missed_trigger_o,
    input wire logic supply_fail_o
);
    wire r = mcu_reset_output_o;
    wire e = system_enable_output_o;
    wire a = trigger_accepted_o;
    logic [15:0] low_cnt;
    always_ff @(posedge clk_sys_i) begin
        if (reset_i || r) begin
            low_cnt <= 16'h0000;
        end else begin
            low_cnt <= low_cnt + 16'h0001;
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    rst_oe_a: assert property (mcu_reset_output_oe_o == !r)
        else $error("reset drive not inverse of level");
    en_oe_a: assert property (system_enable_output_oe_o == !e)
        else $error("enable drive not inverse of level");
    en_rst_a: assert property (e |-> r)
        else $error("enable high while reset low");
    en_rise_a: assert property ($rose(e) |-> a || $past(a) || $past(a, 2))
        else $error("enable rose without accepted trigger");
    pre_drop_a: assert property (pretrigger_fault_o |-> ##[0:1] !e)
        else $error("enable kept after pretrigger");
    miss_drop_a: assert property (missed_trigger_o |-> ##[0:1] (!r && !e))
        else $error("reset or enable kept after miss");
    acc_live_a: assert property (a |-> r)
        else $error("trigger accepted while reset low");
    one_event_a: assert property ($onehot0({a, pretrigger_fault_o, missed_trigger_o}))
        else $error("two window events at once");
    rst_hold_a: assert property ($rose(r) |-> low_cnt >= 16'h18F6)
        else $error("reset low period too short");
    supply_a: assert property ($rose(supply_fail_o) |-> !r && !e)
        else $error("supply fail without reset");
endmodule : wwr_top_sva

// >>> tb/wwr_top_tb.sv
`timescale 1ns/10ps
module wwr_top_tb;
    logic       clk_sys_i    = 1'b0;
    logic       reset_i      = 1'b1;
    logic       supply_low_i = 1'b0;
    logic       fire         = 1'b0;
    logic       trig;
    logic       rst, rst_oe, en, en_oe, acc, pre, miss, sfail;
    logic [5:0] mon;
    int         error_cnt    = 0;
    int         cmp_count    = 0;
    assign mon = {sfail, miss, pre, acc, en, rst};
    always #25 clk_sys_i = ~clk_sys_i;
    wwr_top wwr_top_i (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .supply_low_i(supply_low_i),
        .trigger_input_i(trig), .mcu_reset_output_o(rst), .mcu_reset_output_oe_o(rst_oe),
        .system_enable_output_o(en), .system_enable_output_oe_o(en_oe),
        .trigger_accepted_o(acc), .pretrigger_fault_o(pre), .missed_trigger_o(miss),
        .supply_fail_o(sfail));
    wwr_mcu_model wwr_mcu_model_i (.clk_sys_i(clk_sys_i), .fire_i(fire), .trigger_o(trig));
    task automatic check(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s: expected %b, seen %b", what, exp, got);
        end
    endtask : check
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : idle
    // bounded wait on one monitored output, then judged
    task automatic wait_for(input int idx, input logic val, input int maxc, input string what);
        int n;
        n = 0;
        while (mon[idx] !== val && n < maxc) begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
        check(what, val, mon[idx]);
    endtask : wait_for
    task automatic fire_once(input int dly);
        idle(dly);
        fire <= 1'b1;
        @(posedge clk_sys_i);
        fire <= 1'b0;
    endtask : fire_once
    task automatic t_trig(input int dly, input string what);
        fire_once(dly);
        wait_for(2, 1'b1, 600, what);
        idle(3);
        #1;
        check("enable after trigger", 1'b1, en);
    endtask : t_trig
    task automatic t_pre();
        fire_once(1000);
        wait_for(3, 1'b1, 600, "pretrigger");
        wait_for(1, 1'b0, 2, "enable on pretrigger");
        check("enable drive on pretrigger", 1'b1, en_oe);
        idle(4800);
        #1;
        check("reset before start delay", 1'b1, rst);
        wait_for(0, 1'b0, 500, "reset after pretrigger");
        fire_once(100); // refused while reset is low
        idle(6199);
        #1;
        check("watchdog reset length", 1'b0, rst);
        wait_for(0, 1'b1, 200, "reset release");
        check("enable after release", 1'b0, en);
    endtask : t_pre
    task automatic t_miss();
        idle(6200);
        #1;
        check("reset inside open window", 1'b1, rst);
        wait_for(4, 1'b1, 300, "missed trigger");
        wait_for(0, 1'b0, 2, "reset on miss");
        wait_for(1, 1'b0, 2, "enable on miss");
        wait_for(0, 1'b1, 6500, "reset release");
    endtask : t_miss
    task automatic t_supply();
        @(posedge clk_sys_i);
        supply_low_i <= 1'b1;
        idle(1500);
        supply_low_i <= 1'b0;
        idle(3);
        #1;
        check("reset on short dip", 1'b1, rst);
        @(posedge clk_sys_i);
        supply_low_i <= 1'b1;
        idle(1900);
        #1;
        check("reset inside filter", 1'b1, rst);
        wait_for(0, 1'b0, 200, "reset on supply low");
        wait_for(1, 1'b0, 2, "enable on supply low");
        wait_for(5, 1'b1, 3, "supply fail");
        idle(100);
        supply_low_i <= 1'b0;
        idle(6300);
        #1;
        check("reset in recovery delay", 1'b0, rst);
        check("supply fail cleared", 1'b0, sfail);
        wait_for(0, 1'b1, 200, "reset recovery");
    endtask : t_supply
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up
    initial begin
        idle(8);
        reset_i <= 1'b0;
        idle(6300);
        #1;
        check("reset in power-up delay", 1'b0, rst);
        wait_for(0, 1'b1, 200, "power-up release");
        check("reset drive after release", 1'b0, rst_oe);
        t_trig(2948, "late trigger");
        t_trig(3300, "open trigger");
        t_pre();
        t_trig(3300, "trigger after reset");
        t_miss();
        t_trig(3300, "trigger after miss");
        t_supply();
        wrap_up();
    end
    // run needs about 55k cycles; cut off at 80k
    initial begin
        #4000000;
        error_cnt++;
        wrap_up();
    end
endmodule : wwr_top_tb
bind wwr_top wwr_top_sva wwr_top_sva_i (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .supply_low_i(supply_low_i),
    .trigger_input_i(trigger_input_i), .mcu_reset_output_o(mcu_reset_output_o),
    .mcu_reset_output_oe_o(mcu_reset_output_oe_o),
    .system_enable_output_o(system_enable_output_o),
    .system_enable_output_oe_o(system_enable_output_oe_o),
    .trigger_accepted_o(trigger_accepted_o), .pretrigger_fault_o(pretrigger_fault_o),
    .missed_trigger_o(missed_trigger_o), .supply_fail_o(supply_fail_o));
